//--- fdb_pkg.sv
// Package for the fractional divider configuration bank: map, layout and carrier types.
package fdb_pkg;

   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int          NUM_DIV    = 5;
   localparam int          NUM_W      = 44;
   localparam int          DEN_W      = 32;
   localparam int          STEP_W     = 44;
   localparam int          NUM_BYTES  = 6;
   localparam int          DEN_BYTES  = 4;
   localparam int          ADDR_W     = 16;

   // ----------------------------------------------------------------
   // Register map, byte addresses on the serial control port
   // ----------------------------------------------------------------
   localparam logic [15:0] MAP_LO     = 16'h0302;
   localparam logic [15:0] MAP_HI     = 16'h0358;
   localparam int          MAP_BYTES  = 87;
   localparam logic [15:0] NUM_BASE  [NUM_DIV] = '{16'h0302, 16'h030D, 16'h0318, 16'h0323, 16'h032E};
   localparam logic [15:0] DEN_BASE  [NUM_DIV] = '{16'h0308, 16'h0313, 16'h031E, 16'h0329, 16'h0334};
   localparam logic [15:0] APPLY_ADR [NUM_DIV] = '{16'h030C, 16'h0317, 16'h0322, 16'h032D, 16'h0338};
   localparam logic [15:0] STEP_BASE [NUM_DIV] = '{16'h033B, 16'h0341, 16'h0347, 16'h034D, 16'h0353};
   localparam logic [15:0] GLOBAL_ADR = 16'h0338;
   localparam logic [15:0] MASK_ADR   = 16'h0339;
   localparam logic [15:0] SPARE_ADR  = 16'h033A;

   // ----------------------------------------------------------------
   // Field positions and storage masks
   // ----------------------------------------------------------------
   localparam int          APPLY_BIT  = 0;
   localparam int          GLOBAL_BIT = 1;
   localparam int          TOP_OFS    = 5;
   localparam logic [7:0]  FULL_MASK  = 8'hFF;
   localparam logic [7:0]  TOP_MASK   = 8'h0F;
   localparam logic [7:0]  SMASK_MASK = 8'h1F;
   localparam logic [7:0]  NONE_MASK  = 8'h00;
   localparam logic [7:0]  RESET_BYTE = 8'h00;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        wdata;
   } fdb_req_t;

   typedef logic [NUM_DIV-1:0][NUM_W-1:0] fdb_num_bus_t;
   typedef logic [NUM_DIV-1:0][DEN_W-1:0] fdb_den_bus_t;

endpackage

//--- fdb_config_bank.sv
// Configuration register bank for five interpolative fractional output dividers.
//
// Notes on behaviour
// [R1] Divider 0 numerator: 44 bits over six bytes, low byte first, top byte four bits.
// [R2] Divider 0 denominator: 32 bits over four bytes, low byte at lowest address.
// [R3] Dividers 1 to 4 have numerator and denominator laid out like divider 0.
// [R4] Each divider is fractional; its settings feed the following output post-divider.
// [R5] Divider 0 keeps old settings until bit 0 of its apply register is written 1.
// [R6] Dividers 1, 2, 3 have their own bit-0 apply strobes, each affecting only itself.
// [R7] Divider 4 applies on bit 0 of the register holding the shared strobe.
// [R8] Host writes all new bytes first, then sets that divider's apply strobe.
// [R9] Writing 1 to bit 1 of the shared register loads all dividers together; the code loads only dividers marked changed.
// [R10] A divider not rewritten is left untouched by the shared apply strobe.
// [R11] With the shared strobe set, host writes 0 to all other bits of that byte.
// [R12] Five-bit step mask: 0 lets step requests act on a divider, 1 blocks them.
// [R13] Step mask bits 0 to 4 map one-to-one onto dividers 0 to 4.
// [R14] Divider 0 step word: 44 bits over six bytes, low byte first.
// [R15] Dividers 1 to 4 have step words like divider 0 in consecutive six-byte ranges.
// [R16] Decrement adds the step word to the working numerator; increment subtracts it.
// [R17] Step requests never change the programmed numerator register.
// [R18] Apply strobe bits are one-shot and read back as 0.
// [R19] Steps accumulate in a working numerator reloaded whenever the divider applies.
`timescale 1ns/1ps
`default_nettype none

module fdb_config_bank
(
   input  wire logic                 clk_i,
   input  wire logic                 rst_n_i,
   input  wire fdb_pkg::fdb_req_t    req_i,
   input  wire logic                 freq_increment_request_i,
   input  wire logic                 freq_decrement_request_i,
   output logic [7:0]                rd_data_o,
   output logic                      rd_valid_o,
   output fdb_pkg::fdb_num_bus_t     divider_numerator_o,
   output fdb_pkg::fdb_den_bus_t     divider_denominator_o
);

   // ----------------------------------------------------------------
   // Storage and decode
   // ----------------------------------------------------------------
   logic [7:0]                       map_mem [fdb_pkg::MAP_BYTES];
   logic [fdb_pkg::NUM_DIV-1:0]      dirty;
   logic [2:0]                       inc_sync;
   logic [2:0]                       dec_sync;

   wire                              in_map   = (req_i.addr >= fdb_pkg::MAP_LO) && (req_i.addr <= fdb_pkg::MAP_HI);
   wire  [15:0]                      map_ofs  = req_i.addr - fdb_pkg::MAP_LO;
   wire  [6:0]                       map_idx  = map_ofs[6:0];
   wire                              wr_hit   = req_i.wr && in_map;
   wire                              rd_hit   = req_i.rd && in_map;
   wire  [7:0]                       wr_mask  = store_mask(req_i.addr);
   wire                              global_go;
   wire  [fdb_pkg::NUM_DIV-1:0]      apply_go;
   wire  [fdb_pkg::NUM_DIV-1:0]      touch;
   wire  [fdb_pkg::NUM_DIV-1:0]      step_mask;
   wire                              inc_pulse;
   wire                              dec_pulse;
   wire                              step_go;
   logic [47:0]                      num_bytes  [fdb_pkg::NUM_DIV];
   logic [31:0]                      den_bytes  [fdb_pkg::NUM_DIV];
   logic [47:0]                      step_bytes [fdb_pkg::NUM_DIV];

   // Storable bits of a byte address; apply strobes store nothing so they read as zero.
   function automatic logic [7:0] store_mask(input logic [15:0] adr);
      logic [7:0] m;
      m = fdb_pkg::FULL_MASK;
      for (int i = 0; i < fdb_pkg::NUM_DIV; i++)
      begin
         if ((adr == fdb_pkg::NUM_BASE[i] + 16'(fdb_pkg::TOP_OFS)) ||
             (adr == fdb_pkg::STEP_BASE[i] + 16'(fdb_pkg::TOP_OFS)))
            m = fdb_pkg::TOP_MASK;                                    // R1
         if (adr == fdb_pkg::APPLY_ADR[i])
            m = fdb_pkg::NONE_MASK;                                   // R18
      end
      if (adr == fdb_pkg::MASK_ADR)
         m = fdb_pkg::SMASK_MASK;                                     // R12
      if (adr == fdb_pkg::SPARE_ADR)
         m = fdb_pkg::NONE_MASK;
      return m;
   endfunction

   // Byte index of an address inside the map.
   function automatic int map_at(input logic [15:0] adr);
      return int'(adr - fdb_pkg::MAP_LO);
   endfunction

   // ----------------------------------------------------------------
   // Field assembly and per-divider decode
   // ----------------------------------------------------------------
   genvar gi;
   genvar gb;
   generate
      for (gi = 0; gi < fdb_pkg::NUM_DIV; gi++)
      begin : g_div
         for (gb = 0; gb < fdb_pkg::NUM_BYTES; gb++)
         begin : g_nb
            assign num_bytes[gi][gb*8 +: 8]  = map_mem[map_at(fdb_pkg::NUM_BASE[gi]) + gb];   // R1 R3
            assign step_bytes[gi][gb*8 +: 8] = map_mem[map_at(fdb_pkg::STEP_BASE[gi]) + gb];  // R14 R15
         end
         for (gb = 0; gb < fdb_pkg::DEN_BYTES; gb++)
         begin : g_db
            assign den_bytes[gi][gb*8 +: 8]  = map_mem[map_at(fdb_pkg::DEN_BASE[gi]) + gb];   // R2 R3
         end
         // Any numerator or denominator byte written since the last apply marks the divider changed.
         assign touch[gi]    = wr_hit && (req_i.addr >= fdb_pkg::NUM_BASE[gi]) &&
                               (req_i.addr < fdb_pkg::DEN_BASE[gi] + 16'(fdb_pkg::DEN_BYTES));
         // Per-divider strobe, or the shared strobe for a changed divider only.
         assign apply_go[gi] = (wr_hit && (req_i.addr == fdb_pkg::APPLY_ADR[gi]) &&
                                req_i.wdata[fdb_pkg::APPLY_BIT]) ||                   // R5 R6 R7
                               (global_go && dirty[gi]);                             // R9 R10
         assign step_mask[gi] = map_mem[map_at(fdb_pkg::MASK_ADR)][gi];              // R13
      end
   endgenerate

   // The host is expected to leave the other bits zero with the shared strobe; divider 4's bit is honoured anyway.
   assign global_go = wr_hit && (req_i.addr == fdb_pkg::GLOBAL_ADR) &&
                      req_i.wdata[fdb_pkg::GLOBAL_BIT];                               // R9 R11
   assign inc_pulse = inc_sync[1] && !inc_sync[2];
   assign dec_pulse = dec_sync[1] && !dec_sync[2];
   // Simultaneous increment and decrement cancel, so neither is applied.
   assign step_go   = inc_pulse ^ dec_pulse;

   // ----------------------------------------------------------------
   // Register storage and read port
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         for (int i = 0; i < fdb_pkg::MAP_BYTES; i++)
            map_mem[i] <= fdb_pkg::RESET_BYTE;
      end
      else if (wr_hit)
      begin
         map_mem[map_idx] <= req_i.wdata & wr_mask;                   // R17 R18
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         rd_data_o  <= fdb_pkg::RESET_BYTE;
         rd_valid_o <= 1'b0;
      end
      else
      begin
         rd_valid_o <= req_i.rd;
         rd_data_o  <= rd_hit ? map_mem[map_idx] : fdb_pkg::RESET_BYTE;
      end
   end

   // ----------------------------------------------------------------
   // Step request pins
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         inc_sync <= 3'b000;
         dec_sync <= 3'b000;
      end
      else
      begin
         inc_sync <= {inc_sync[1:0], freq_increment_request_i};
         dec_sync <= {dec_sync[1:0], freq_decrement_request_i};
      end
   end

   // ----------------------------------------------------------------
   // Active divider settings
   // ----------------------------------------------------------------
   // The apply wins over a step in the same cycle: the working numerator restarts from the register.
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         dirty                 <= '0;
         divider_numerator_o   <= '0;
         divider_denominator_o <= '0;
      end
      else
      begin
         dirty <= (dirty & ~apply_go) | touch;                         // R8 R10
         for (int i = 0; i < fdb_pkg::NUM_DIV; i++)
         begin
            if (apply_go[i])
            begin
               divider_numerator_o[i]   <= num_bytes[i][fdb_pkg::NUM_W-1:0];   // R4 R5 R19
               divider_denominator_o[i] <= den_bytes[i];                      // R4 R5
            end
            else if (step_go && !step_mask[i])                                // R12
            begin
               if (dec_pulse)
                  divider_numerator_o[i] <= divider_numerator_o[i] +
                                            step_bytes[i][fdb_pkg::STEP_W-1:0];   // R16 R19
               else
                  divider_numerator_o[i] <= divider_numerator_o[i] -
                                            step_bytes[i][fdb_pkg::STEP_W-1:0];   // R16 R19
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   strobe_reads_zero_a: assert property ( // R18
      (req_i.rd && (req_i.addr == fdb_pkg::APPLY_ADR[0] || req_i.addr == fdb_pkg::GLOBAL_ADR)) |=> rd_data_o == 8'h00)
      else $error("apply strobe byte did not read back as zero");

   top_nibble_a: assert property ( // R1
      (req_i.rd && req_i.addr == fdb_pkg::NUM_BASE[0] + 16'(fdb_pkg::TOP_OFS)) |=> rd_data_o[7:4] == 4'h0)
      else $error("numerator top byte shows bits above bit 43");

   apply_loads_a: assert property ( // R5
      (wr_hit && req_i.addr == fdb_pkg::APPLY_ADR[0] && req_i.wdata[0]) |=>
      divider_numerator_o[0] == $past(num_bytes[0][43:0]) && divider_denominator_o[0] == $past(den_bytes[0]))
      else $error("divider 0 apply did not load its programmed values");

   hold_no_apply_a: assert property ( // R5
      !apply_go[1] |=> divider_denominator_o[1] == $past(divider_denominator_o[1]))
      else $error("divider 1 denominator changed without an apply");

   global_apply_a: assert property ( // R9
      (global_go && dirty[2]) |=> divider_denominator_o[2] == $past(den_bytes[2]))
      else $error("shared apply did not load a changed divider");

   clean_untouched_a: assert property ( // R10
      (global_go && !dirty[3] && !step_go && !touch[3]) |=>
      divider_numerator_o[3] == $past(divider_numerator_o[3]))
      else $error("shared apply disturbed an unchanged divider");

   masked_step_a: assert property ( // R12
      (step_go && step_mask[0] && !apply_go[0]) |=> $stable(divider_numerator_o[0]))
      else $error("masked divider moved on a step request");

   dec_adds_a: assert property ( // R16
      (dec_pulse && !inc_pulse && !step_mask[1] && !apply_go[1]) |=>
      divider_numerator_o[1] == $past(divider_numerator_o[1]) + $past(step_bytes[1][43:0]))
      else $error("decrement did not add the step word");

   inc_subs_a: assert property ( // R16
      (inc_pulse && !dec_pulse && !step_mask[4] && !apply_go[4]) |=>
      divider_numerator_o[4] == $past(divider_numerator_o[4]) - $past(step_bytes[4][43:0]))
      else $error("increment did not subtract the step word");

   num_reg_kept_a: assert property ( // R17
      (step_go && !wr_hit) |=> $stable(num_bytes[2]))
      else $error("numerator register changed by a step request");

   pin_sync_a: assert property ( // R16
      $rose(freq_increment_request_i) |-> ##2 inc_pulse)
      else $error("increment request not seen two cycles after the pin rose");

   // ----------------------------------------------------------------
   // Register port checks
   // ----------------------------------------------------------------
   read_valid_a: assert property ( // R2
      req_i.rd |=>
      rd_valid_o)
      else $error("read request not answered with valid");

   valid_idle_a: assert property ( // R2
      !req_i.rd |=>
      !rd_valid_o)
      else $error("valid raised without a read request");

   idle_data_zero_a: assert property ( // R3
      !req_i.rd |=>
      rd_data_o == 8'h00)
      else $error("read data not zero without a read");

   unmapped_read_a: assert property ( // R3
      (req_i.rd && !in_map) |=>
      rd_data_o == 8'h00)
      else $error("unmapped address did not read as zero");

   mask_width_a: assert property ( // R12
      (req_i.rd && req_i.addr == fdb_pkg::MASK_ADR) |=>
      rd_data_o[7:5] == 3'b000)
      else $error("step mask byte shows bits above bit 4");

   step_top_a: assert property ( // R15
      (req_i.rd && req_i.addr == fdb_pkg::STEP_BASE[4] + 16'(fdb_pkg::TOP_OFS)) |=>
      rd_data_o[7:4] == 4'h0)
      else $error("step word top byte shows bits above bit 43");

   num_store_a: assert property ( // R3
      (wr_hit && req_i.addr == fdb_pkg::NUM_BASE[1]) |=>
      num_bytes[1][7:0] == $past(req_i.wdata))
      else $error("numerator low byte not stored");

   den_store_a: assert property ( // R2
      (wr_hit && req_i.addr == fdb_pkg::DEN_BASE[0] + 16'h0003) |=>
      den_bytes[0][31:24] == $past(req_i.wdata))
      else $error("denominator top byte not stored");

   step_store_a: assert property ( // R14
      (wr_hit && req_i.addr == fdb_pkg::STEP_BASE[2]) |=>
      step_bytes[2][7:0] == $past(req_i.wdata))
      else $error("step word low byte not stored");

   // ----------------------------------------------------------------
   // Apply and step checks
   // ----------------------------------------------------------------
   dirty_marks_a: assert property ( // R10
      touch[1] |=>
      dirty[1])
      else $error("written divider not marked changed");

   dirty_clears_a: assert property ( // R10
      (apply_go[3] && !touch[3]) |=>
      !dirty[3])
      else $error("changed mark not cleared by an apply");

   div4_apply_a: assert property ( // R7
      (wr_hit && req_i.addr == fdb_pkg::GLOBAL_ADR && req_i.wdata[fdb_pkg::APPLY_BIT]) |=>
      divider_denominator_o[4] == $past(den_bytes[4]))
      else $error("divider 4 apply did not load its denominator");

   own_apply_only_a: assert property ( // R6
      (apply_go[1] && !apply_go[0] && !step_go) |=>
      $stable(divider_numerator_o[0]) && $stable(divider_denominator_o[0]))
      else $error("divider 1 apply disturbed divider 0");

   den_apply_a: assert property ( // R6
      apply_go[3] |=>
      divider_denominator_o[3] == $past(den_bytes[3]))
      else $error("divider 3 apply did not load its denominator");

   apply_reload_a: assert property ( // R19
      apply_go[2] |=>
      divider_numerator_o[2] == $past(num_bytes[2][43:0]))
      else $error("apply did not restart the working numerator");

   step_cancel_a: assert property ( // R16
      (inc_pulse && dec_pulse && !apply_go[3]) |=>
      $stable(divider_numerator_o[3]))
      else $error("opposed step requests moved a divider");

   den_no_step_a: assert property ( // R16
      (step_go && !apply_go[0]) |=>
      $stable(divider_denominator_o[0]))
      else $error("step request changed a denominator");

   masked_div4_a: assert property ( // R13
      (step_go && step_mask[4] && !apply_go[4]) |=>
      $stable(divider_numerator_o[4]))
      else $error("mask bit 4 did not block divider 4");

   inc_once_a: assert property ( // R16
      inc_pulse |=>
      !inc_pulse)
      else $error("increment request acted twice");

   dec_once_a: assert property ( // R16
      dec_pulse |=>
      !dec_pulse)
      else $error("decrement request acted twice");

   cover_global_c: cover property (global_go && dirty[0] && dirty[4]);
   cover_step_c:   cover property (dec_pulse ##[1:20] inc_pulse);
   cover_apply_c:  cover property (touch[3] ##[1:20] apply_go[3]);
   cover_cancel_c: cover property (inc_pulse && dec_pulse);
   cover_masked_c: cover property (step_go && step_mask[4]);

endmodule

`default_nettype wire

//--- fdb_host_model.sv
// Host model that issues byte register requests and drives the step request pins.
`timescale 1ns/1ps
`default_nettype none

module fdb_host_model
(
   input  wire logic              clk_i,
   input  wire logic              rd_valid_i,
   input  wire logic [7:0]        rd_data_i,
   output var  fdb_pkg::fdb_req_t req_o,
   output logic                   inc_o,
   output logic                   dec_o
);
   initial
   begin
      req_o = '0;
      inc_o = 1'b0;
      dec_o = 1'b0;
   end

   // Released address and data lines are inverted so a stale value never looks valid.
   task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d,
                         output logic [7:0] q, output logic v);
      @(negedge clk_i);
      req_o = '{wr: wr, rd: !wr, addr: a, wdata: d};
      @(negedge clk_i);
      v = rd_valid_i;
      q = rd_data_i;
      req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask

   // Pin stays high and then low for more than two cycles so the synchroniser sees one edge.
   task automatic pulse(input logic [1:0] sel);
      @(negedge clk_i);
      inc_o = sel[1];
      dec_o = sel[0];
      repeat (3) @(negedge clk_i);
      inc_o = 1'b0;
      dec_o = 1'b0;
      repeat (4) @(negedge clk_i);
   endtask
endmodule

`default_nettype wire

//--- tb_fractional_divider_config_bank.sv
// Self-checking testbench for the fractional divider configuration bank.
`timescale 1ns/1ps
`default_nettype none
`define FDB_CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
   $display("wrong value at %0t: output differs from model", $time); end end

module tb_fractional_divider_config_bank;
   logic                  clk_i = 1'b0;
   logic                  rst_n_i = 1'b0;
   fdb_pkg::fdb_req_t     req;
   logic                  inc;
   logic                  dec;
   logic                  rd_valid;
   logic [7:0]            rd_data;
   fdb_pkg::fdb_num_bus_t num_o;
   fdb_pkg::fdb_den_bus_t den_o;
   logic [43:0]           m_reg [5];
   logic [43:0]           m_work [5];
   logic [43:0]           m_step [5];
   logic [31:0]           m_den [5];
   logic [31:0]           m_act [5];
   logic [4:0]            m_dirty = '0;
   logic [4:0]            m_mask;
   logic [31:0]           seed = 32'h0000_002A;
   int                    error_cnt = 0;
   int                    n_compared = 0;

   always #2.5 clk_i = ~clk_i;

   fdb_config_bank fdb_config_bank_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req),
      .freq_increment_request_i(inc), .freq_decrement_request_i(dec), .rd_data_o(rd_data),
      .rd_valid_o(rd_valid), .divider_numerator_o(num_o), .divider_denominator_o(den_o));
   fdb_host_model host_inst (.clk_i(clk_i), .rd_valid_i(rd_valid), .rd_data_i(rd_data),
      .req_o(req), .inc_o(inc), .dec_o(dec));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      logic [7:0] q;
      logic       v;
      host_inst.access(1'b1, a, d, q, v);
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
      logic [7:0] q;
      logic       v;
      host_inst.access(1'b0, a, 8'h00, q, v);
      `FDB_CHK(v, 1'b1)
      `FDB_CHK(q, e)
   endtask

   task automatic wr_field(input logic [15:0] a, input logic [43:0] val, input int n);
      for (int i = 0; i < n; i++)
         wr(a + 16'(i), 8'(val >> (8 * i)));
   endtask

   task automatic apply_model(input logic [4:0] sel);
      for (int d = 0; d < 5; d++)
      begin
         if (sel[d])
         begin
            m_work[d] = m_reg[d];
            m_act[d] = m_den[d];
            m_dirty[d] = 1'b0;
         end
      end
   endtask

   task automatic step_model(input logic up);
      for (int d = 0; d < 5; d++)
         if (!m_mask[d])
            m_work[d] = up ? m_work[d] - m_step[d] : m_work[d] + m_step[d];
   endtask

   task automatic check_outs();
      @(negedge clk_i);
      for (int d = 0; d < 5; d++)
      begin
         `FDB_CHK(num_o[d], m_work[d])
         `FDB_CHK(den_o[d], m_act[d])
      end
   endtask

   task automatic new_div(input int d);
      m_reg[d] = 44'({xs(), xs()});
      m_den[d] = xs();
      m_dirty[d] = 1'b1;
      wr_field(fdb_pkg::NUM_BASE[d], m_reg[d], 6);
      wr_field(fdb_pkg::DEN_BASE[d], {12'h000, m_den[d]}, 4);
   endtask

   task automatic stop_test();
      $display("checks made %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial
   begin
      for (int d = 0; d < 5; d++)
      begin
         m_reg[d] = '0;
         m_work[d] = '0;
         m_step[d] = '0;
         m_den[d] = '0;
         m_act[d] = '0;
      end
      repeat (6) @(negedge clk_i);
      rst_n_i = 1'b1;
      check_outs();
      rd_chk(16'h0302, 8'h00);
      for (int d = 0; d < 5; d++)
      begin
         new_div(d);
         check_outs();
         wr(fdb_pkg::APPLY_ADR[d], 8'h01);
         apply_model(5'(1 << d));
         check_outs();
         rd_chk(fdb_pkg::APPLY_ADR[d], 8'h00);
         rd_chk(fdb_pkg::NUM_BASE[d] + 16'h0005, {4'h0, m_reg[d][43:40]});
         rd_chk(fdb_pkg::DEN_BASE[d] + 16'h0003, m_den[d][31:24]);
      end
      new_div(1);
      new_div(3);
      wr(fdb_pkg::GLOBAL_ADR, 8'h02);
      apply_model(m_dirty);
      check_outs();
      for (int r = 0; r < 3; r++)
      begin
         for (int d = 0; d < 5; d++)
         begin
            m_step[d] = 44'({xs(), xs()});
            wr_field(fdb_pkg::STEP_BASE[d], m_step[d], 6);
         end
         m_mask = (r == 0) ? 5'h00 : 5'(xs());
         wr(fdb_pkg::MASK_ADR, {3'b000, m_mask});
         rd_chk(fdb_pkg::MASK_ADR, {3'b000, m_mask});
         host_inst.pulse(2'h1);
         step_model(1'b0);
         check_outs();
         host_inst.pulse(2'h2);
         step_model(1'b1);
         host_inst.pulse(2'h2);
         step_model(1'b1);
         check_outs();
         rd_chk(fdb_pkg::NUM_BASE[2], m_reg[2][7:0]);
         rd_chk(fdb_pkg::STEP_BASE[4] + 16'h0005, {4'h0, m_step[4][43:40]});
      end
      host_inst.pulse(2'h3);
      check_outs();
      wr(fdb_pkg::APPLY_ADR[0], 8'h01);
      apply_model(5'h01);
      check_outs();
      wr(16'h0359, 8'hFF);
      rd_chk(16'h0359, 8'h00);
      rd_chk(16'h0301, 8'h00);
      stop_test();
   end

   initial
   begin
      #100000;
      error_cnt++;
      stop_test();
   end
endmodule

`default_nettype wire
